/* File: rtl/ald_core.sv */
// Arithmetic and logic datapath: decrement, logic, add and subtract families
`timescale 1ns/1ps
`include "ald_regs.svh"
module ald_core import ald_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire ald_req_t REQ,
  input wire logic CARRY_IN,
  input wire logic ZERO_IN,
  output ald_res_t RES,
  output logic CARRY_OUT,
  output logic ZERO_OUT
);

  // ==========================================================
  // Operand selection
  // Request comes from the decoder on this clock, so no synchroniser.
  // Flag inputs let the register file own the flags; the outputs here
  // track them so an unaffected flag is carried through untouched.
  function automatic logic [WIDTH-1:0] pick_b(input ald_req_t r);
    case (r.src)
      ALD_SRC_IMM: pick_b = r.imm;
      ALD_SRC_R3: pick_b = r.reg3;
      ALD_SRC_R2: pick_b = r.reg2;
      ALD_SRC_MEM: pick_b = r.mem;
      default: pick_b = r.imm;
    endcase
  endfunction

  // First operand: reg2 in three-register forms, otherwise the named register
  function automatic logic [WIDTH-1:0] pick_a(input ald_req_t r);
    if (r.src == ALD_SRC_R3) begin
      pick_a = r.reg2;
    end else begin
      pick_a = r.reg1;
    end
  endfunction

  // Decrement source: memory, reg2 in the two-register form, else the named register
  function automatic logic [WIDTH-1:0] pick_dec(input ald_req_t r);
    case (r.src)
      ALD_SRC_MEM: pick_dec = r.mem;
      ALD_SRC_R2: pick_dec = r.reg2;
      default: pick_dec = r.reg1;
    endcase
  endfunction

  // Reversed-order minuend: reg2 in the three-register form, else the operand
  function automatic logic [WIDTH-1:0] pick_sub_x(input ald_req_t r);
    case (r.src)
      ALD_SRC_R3: pick_sub_x = r.reg2;
      default: pick_sub_x = pick_b(r);
    endcase
  endfunction

  // Reversed-order subtrahend: reg3 in the three-register form, else the named register
  function automatic logic [WIDTH-1:0] pick_sub_y(input ald_req_t r);
    case (r.src)
      ALD_SRC_R3: pick_sub_y = r.reg3;
      default: pick_sub_y = r.reg1;
    endcase
  endfunction

  // Unit step for the plain decrement
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  // Subtraction x - y - borrow; top bit of the wide result is the borrow
  function automatic logic [WIDTH:0] sub_w(input logic [WIDTH-1:0] x,
                                           input logic [WIDTH-1:0] y,
                                           input logic bin);
    sub_w = {1'b0, x} - {1'b0, y} - {{WIDTH{1'b0}}, bin};
  endfunction

  // ==========================================================
  // Opcode classes
  // Only the arithmetic families own the carry; logic ops pass it through
  function automatic logic writes_carry(input ald_op_t op);
    case (op)
      ALD_OP_DEC,
      ALD_OP_DECC,
      ALD_OP_ADD,
      ALD_OP_ADDC,
      ALD_OP_SUBD,
      ALD_OP_SUBDC,
      ALD_OP_SUBS,
      ALD_OP_SUBSC: writes_carry = 1'b1;
      ALD_OP_AND,
      ALD_OP_OR,
      ALD_OP_XOR: writes_carry = 1'b0;
      default: writes_carry = 1'b0;
    endcase
  endfunction

  // Chained forms take the incoming carry as an addend or an inverted borrow
  function automatic logic chains_carry(input ald_op_t op);
    case (op)
      ALD_OP_DECC,
      ALD_OP_ADDC,
      ALD_OP_SUBDC,
      ALD_OP_SUBSC: chains_carry = 1'b1;
      ALD_OP_DEC,
      ALD_OP_ADD,
      ALD_OP_SUBD,
      ALD_OP_SUBS: chains_carry = 1'b0;
      default: chains_carry = 1'b0;
    endcase
  endfunction

  // Straight order subtracts the operand from the register
  function automatic logic is_straight(input ald_op_t op);
    case (op)
      ALD_OP_SUBS,
      ALD_OP_SUBSC: is_straight = 1'b1;
      ALD_OP_SUBD,
      ALD_OP_SUBDC: is_straight = 1'b0;
      default: is_straight = 1'b0;
    endcase
  endfunction

  // Zero test shared by the result word and the flag register
  function automatic logic is_zero(input logic [WIDTH-1:0] r);
    is_zero = (r == `ALD_ZERO_BYTE);
  endfunction

  // Families that do not own the carry hand the incoming one straight on
  function automatic logic carry_after(input ald_op_t op,
                                       input logic [WIDTH:0] c,
                                       input logic cin);
    if (writes_carry(op)) begin
      carry_after = c[WIDTH];
    end else begin
      carry_after = cin;
    end
  endfunction

  // Index step travels with the memory access, never on its own
  function automatic logic idx_step(input ald_req_t r);
    idx_step = r.idx_update && (r.src == ALD_SRC_MEM);
  endfunction

  // ==========================================================
  // Family arithmetic, each returning {carry, result}

  // Decrement by one, or by one minus carry in the chained form
  function automatic logic [WIDTH:0] dec_calc(input logic [WIDTH-1:0] s,
                                              input logic cin,
                                              input logic chained);
    logic [WIDTH:0] w;
    logic [WIDTH-1:0] r;
    logic hit_ff;
    logic cy;
    if (chained) begin
      w = sub_w(s, '0, ~cin);
    end else begin
      w = sub_w(s, ONE, 1'b0);
    end
    r = w[WIDTH-1:0];
    hit_ff = (r == `ALD_ALL_ONES);
    if (chained) begin
      cy = !(hit_ff && !cin);
    end else begin
      cy = !hit_ff;
    end
    dec_calc = {cy, r};
  endfunction

  // Bitwise families leave the carry column at zero; the caller keeps the old carry
  function automatic logic [WIDTH:0] logic_calc(input ald_op_t op,
                                                input logic [WIDTH-1:0] a,
                                                input logic [WIDTH-1:0] b);
    logic [WIDTH-1:0] r;
    case (op)
      ALD_OP_AND: begin
        r = a & b;
      end
      ALD_OP_OR: begin
        r = a | b;
      end
      // Memory form is a true XOR as well, matching its register forms
      ALD_OP_XOR: begin
        r = a ^ b;
      end
      default: begin
        r = '0;
      end
    endcase
    logic_calc = {1'b0, r};
  endfunction

  // Addition, with the incoming carry as an extra addend in the chained form
  function automatic logic [WIDTH:0] add_calc(input logic [WIDTH-1:0] a,
                                              input logic [WIDTH-1:0] b,
                                              input logic cin,
                                              input logic chained);
    logic [WIDTH:0] w;
    logic [WIDTH:0] extra;
    extra = {{WIDTH{1'b0}}, chained & cin};
    w = {1'b0, a} + {1'b0, b} + extra;
    add_calc = w;
  endfunction

  // Subtraction; carry is the inverted borrow out of the top bit
  // The borrow rides in a wider word, so no separate compare is needed
  function automatic logic [WIDTH:0] sub_calc(input logic [WIDTH-1:0] x,
                                              input logic [WIDTH-1:0] y,
                                              input logic cin,
                                              input logic chained);
    logic [WIDTH:0] w;
    logic bin;
    bin = chained & ~cin;
    w = sub_w(x, y, bin);
    sub_calc = {~w[WIDTH], w[WIDTH-1:0]};
  endfunction

  // ==========================================================
  // Operand routing
  logic [WIDTH-1:0] opa;
  logic [WIDTH-1:0] opb;
  logic [WIDTH-1:0] dec_src;
  logic [WIDTH-1:0] sub_x;
  logic [WIDTH-1:0] sub_y;

  always_comb begin
    opa = pick_a(REQ);
    opb = pick_b(REQ);
    dec_src = pick_dec(REQ);
    sub_x = pick_sub_x(REQ);
    sub_y = pick_sub_y(REQ);
  end

  // ==========================================================
  // Result computation
  logic [WIDTH:0] calc;
  logic [WIDTH-1:0] result;
  logic c_new;

  always_comb begin
    case (REQ.op)
      ALD_OP_DEC,
      ALD_OP_DECC: begin
        calc = dec_calc(dec_src, CARRY_IN, chains_carry(REQ.op));
      end
      ALD_OP_AND,
      ALD_OP_OR,
      ALD_OP_XOR: begin
        calc = logic_calc(REQ.op, opa, opb);
      end
      ALD_OP_ADD,
      ALD_OP_ADDC: begin
        calc = add_calc(opa, opb, CARRY_IN, chains_carry(REQ.op));
      end
      ALD_OP_SUBD,
      ALD_OP_SUBDC,
      ALD_OP_SUBS,
      ALD_OP_SUBSC: begin
        // Straight order swaps the reversed operands: reg3-reg2, reg1-reg2, reg-op
        if (is_straight(REQ.op)) begin
          calc = sub_calc(sub_y, sub_x, CARRY_IN, chains_carry(REQ.op));
        end else begin
          calc = sub_calc(sub_x, sub_y, CARRY_IN, chains_carry(REQ.op));
        end
      end
      default: begin
        calc = '0;
      end
    endcase
    result = calc[WIDTH-1:0];
    c_new = carry_after(REQ.op, calc, CARRY_IN);
  end

  // ==========================================================
  // Result register
  // One request gives a single-cycle result word; idle cycles clear it
  function automatic ald_res_t pack_result(input ald_req_t r,
                                           input logic [WIDTH-1:0] value,
                                           input logic carry);
    pack_result = '0;
    pack_result.valid = 1'b1;
    pack_result.dest = r.dest;
    pack_result.value = value;
    pack_result.acc = value;
    pack_result.carry = carry;
    pack_result.zero = is_zero(value);
    pack_result.idx_update = idx_step(r);
    pack_result.idx_sel = r.idx_sel;
  endfunction

  ald_res_t res_reg;
  ald_res_t res_next;

  always_comb begin
    res_next = '0;
    if (REQ.valid) begin
      res_next = pack_result(REQ, result, c_new);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  // ==========================================================
  // Flag registers
  // Flags are owned outside; between requests they mirror the owner a cycle late
  logic carry_reg;
  logic carry_next;
  logic zero_reg;
  logic zero_next;

  always_comb begin
    if (REQ.valid) begin
      carry_next = c_new;
      zero_next = is_zero(result);
    end else begin
      carry_next = CARRY_IN;
      zero_next = ZERO_IN;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      carry_reg <= `ALD_RESET_FLAG;
      zero_reg <= `ALD_RESET_FLAG;
    end else begin
      carry_reg <= carry_next;
      zero_reg <= zero_next;
    end
  end

  assign RES = res_reg;
  assign CARRY_OUT = carry_reg;
  assign ZERO_OUT = zero_reg;

endmodule

/* File: include/ald_regs.svh */
// Constants for the arithmetic and logic datapath
`ifndef ALD_REGS_SVH
`define ALD_REGS_SVH
`define ALD_ALL_ONES 8'hff
`define ALD_ZERO_BYTE 8'h00
`define ALD_RESET_BYTE 8'h00
`define ALD_RESET_FLAG 1'b0
`endif

/* File: include/ald_pkg.sv */
// Types shared by the arithmetic and logic datapath
package ald_pkg;
  typedef enum logic [3:0] {
    ALD_OP_DEC = 4'h0,
    ALD_OP_DECC = 4'h1,
    ALD_OP_AND = 4'h2,
    ALD_OP_OR = 4'h3,
    ALD_OP_XOR = 4'h4,
    ALD_OP_ADD = 4'h5,
    ALD_OP_ADDC = 4'h6,
    ALD_OP_SUBD = 4'h7,
    ALD_OP_SUBDC = 4'h8,
    ALD_OP_SUBS = 4'h9,
    ALD_OP_SUBSC = 4'ha
  } ald_op_t;

  typedef enum logic [1:0] {
    ALD_SRC_IMM = 2'h0,
    ALD_SRC_R3 = 2'h1,
    ALD_SRC_R2 = 2'h2,
    ALD_SRC_MEM = 2'h3
  } ald_src_t;

  typedef struct packed {
    logic valid;
    ald_op_t op;
    ald_src_t src;
    logic [3:0] dest;
    logic [7:0] reg1;
    logic [7:0] reg2;
    logic [7:0] reg3;
    logic [7:0] imm;
    logic [7:0] mem;
    logic idx_update;
    logic [1:0] idx_sel;
  } ald_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] dest;
    logic [7:0] value;
    logic [7:0] acc;
    logic carry;
    logic zero;
    logic idx_update;
    logic [1:0] idx_sel;
  } ald_res_t;
endpackage

/* File: verification/ald_core_assertions.sv */
// Port checker for the datapath
`timescale 1ns/1ps
module ald_core_assertions import ald_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire ald_req_t REQ,
  input wire logic CARRY_IN,
  input wire logic ZERO_IN,
  input wire ald_res_t RES,
  input wire logic CARRY_OUT,
  input wire logic ZERO_OUT
);
  // ====
  // Properties
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire logic lg = REQ.op inside {ALD_OP_AND, ALD_OP_OR, ALD_OP_XOR};
  a_res_latency: assert property (REQ.valid |=> RES.valid) else $error("late");
  a_no_stray: assert property (!REQ.valid |=> !RES.valid) else $error("stray");
  a_zero_flag: assert property (RES.valid |-> RES.zero == (RES.value == 8'h00))
    else $error("zero");
  a_acc_copy: assert property (RES.valid |-> RES.acc == RES.value) else $error("acc");
  a_logic_carry: assert property (REQ.valid && lg |=> RES.carry == $past(CARRY_IN))
    else $error("logic carry");
  a_dec_carry: assert property (REQ.valid && REQ.op == ALD_OP_DEC |=>
    RES.carry == (RES.value != 8'hff)) else $error("dec carry");
  a_index_step: assert property (REQ.valid |=>
    RES.idx_update == ($past(REQ.idx_update) && $past(REQ.src) == ALD_SRC_MEM))
    else $error("index");
  a_flag_hold: assert property (!REQ.valid |=>
    CARRY_OUT == $past(CARRY_IN) && ZERO_OUT == $past(ZERO_IN)) else $error("hold");
  a_flag_out: assert property (RES.valid |->
    CARRY_OUT == RES.carry && ZERO_OUT == RES.zero) else $error("flags");
  cover property (REQ.valid && REQ.op == ALD_OP_SUBSC);
  cover property (RES.valid && RES.carry);
  cover property (REQ.valid && REQ.src == ALD_SRC_MEM && REQ.idx_update);
endmodule

/* File: verification/ald_flag_owner.sv */
// Flag owner model feeding flags back
`timescale 1ns/1ps
module ald_flag_owner import ald_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire ald_res_t res,
  output logic carry_in,
  output logic zero_in
);
  logic carry_reg, carry_next, zero_reg, zero_next;
  // ====
  // Flags
  // Idle cycles keep flags, so the datapath sees the last result's flags between requests
  always_comb begin
    carry_next = res.valid ? res.carry : carry_reg;
    zero_next = res.valid ? res.zero : zero_reg;
  end
  always_ff @(posedge clk) begin
    carry_reg <= rst ? 1'b0 : carry_next;
    zero_reg <= rst ? 1'b0 : zero_next;
  end
  assign carry_in = carry_reg;
  assign zero_in = zero_reg;
endmodule

/* File: verification/ald_core_tb_top.sv */
// Self-checking bench for the datapath
`timescale 1ns/1ps
module ald_core_tb_top import ald_pkg::*;;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  ald_req_t REQ = '0;
  logic CARRY_IN, ZERO_IN, CARRY_OUT, ZERO_OUT;
  ald_res_t RES;
  int n_errors = 0;
  int tests_run = 0;
  // ====
  // Harness
  always #10 REF_CLK = ~REF_CLK;
  ald_core u_ald_core (.REF_CLK(REF_CLK), .RESET(RESET), .REQ(REQ), .CARRY_IN(CARRY_IN),
    .ZERO_IN(ZERO_IN), .RES(RES), .CARRY_OUT(CARRY_OUT), .ZERO_OUT(ZERO_OUT));
  ald_flag_owner u_ald_flag_owner (.clk(REF_CLK), .rst(RESET), .res(RES),
    .carry_in(CARRY_IN), .zero_in(ZERO_IN));
  function automatic logic [8:0] expect_f(ald_req_t q, logic ci);
    logic [7:0] a, b, s, r;
    logic bw;
    logic [8:0] d;
    a = (q.src == ALD_SRC_R3) ? q.reg2 : q.reg1;
    b = (q.src == ALD_SRC_R3) ? q.reg3 : (q.src == ALD_SRC_R2) ? q.reg2 :
      (q.src == ALD_SRC_IMM) ? q.imm : q.mem;
    s = (q.src == ALD_SRC_MEM) ? q.mem : (q.src == ALD_SRC_R2) ? q.reg2 : q.reg1;
    bw = (q.op inside {ALD_OP_SUBDC, ALD_OP_SUBSC}) && !ci;
    r = s - {7'h00, !ci};
    d = ((q.op inside {ALD_OP_SUBD, ALD_OP_SUBDC}) != (q.src == ALD_SRC_R3)) ?
      {1'b0, b} - a - bw : {1'b0, a} - b - bw;
    case (q.op)
      ALD_OP_DEC: return {s != 8'h00, s - 8'h01};
      ALD_OP_DECC: return {!(r == 8'hff && !ci), r};
      ALD_OP_AND: return {ci, a & b};
      ALD_OP_OR: return {ci, a | b};
      ALD_OP_XOR: return {ci, a ^ b};
      ALD_OP_ADD: return {1'b0, a} + b;
      ALD_OP_ADDC: return {1'b0, a} + b + ci;
      default: return {!d[8], d[7:0]};
    endcase
  endfunction
  task automatic chk(logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(ald_req_t q);
    logic [8:0] e;
    logic ci;
    q.valid = 1'b1;
    ci = CARRY_IN;
    e = expect_f(q, ci);
    REQ = q;
    @(negedge REF_CLK);
    REQ.valid = 1'b0;
    chk({8'h00, RES.valid}, 9'h001);
    chk({RES.carry, RES.value}, e);
    chk({RES.zero, RES.acc}, {e[7:0] == 8'h00, e[7:0]});
    chk({8'h00, RES.idx_update}, {8'h00, q.src == ALD_SRC_MEM && q.idx_update});
    chk({1'b0, RES.dest, RES.idx_sel, 2'b00}, {1'b0, q.dest, q.idx_sel, 2'b00});
    chk({7'h00, ZERO_OUT, CARRY_OUT}, {7'h00, e[7:0] == 8'h00, e[8]});
    @(negedge REF_CLK);
    chk({8'h00, RES.valid}, 9'h000);
    chk({8'h00, CARRY_OUT}, {8'h00, ci});
  endtask
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Span is about three times the expected run
  initial begin
    repeat (3000) @(posedge REF_CLK);
    n_errors++;
    results();
  end
  initial begin
    ald_req_t q;
    void'($urandom(32'h5f8d));
    repeat (8) @(negedge REF_CLK);
    RESET = 1'b0;
    for (int k = 0; k < 88; k++) begin
      q = '0;
      {q.reg1, q.reg2, q.reg3, q.imm, q.mem} = (k < 44) ? '0 : '1;
      q.op = ald_op_t'(4'(k % 11));
      q.src = ald_src_t'(2'(k / 11 % 4));
      q.idx_update = k[0];
      run(q);
    end
    $display("Test boundary done");
    for (int k = 0; k < 400; k++) begin
      q = $bits(q)'({$urandom, $urandom});
      q.op = ald_op_t'(4'($urandom_range(10)));
      run(q);
    end
    $display("Test random done");
    results();
  end
endmodule
bind ald_core ald_core_assertions u_ald_core_assertions (.REF_CLK(REF_CLK), .RESET(RESET),
  .REQ(REQ), .CARRY_IN(CARRY_IN), .ZERO_IN(ZERO_IN), .RES(RES), .CARRY_OUT(CARRY_OUT),
  .ZERO_OUT(ZERO_OUT));
